// ==== verilog/front_panel_regs.svh ====
// constants for the front-panel button and indicator controller
// Functional notes
// - brief press steps mode A, B, C, D
// - one idle minute returns to mode A
// - mode LED: off, green, orange, flashing
// - twelve-second hold in A restores defaults
// - early release cancels the default restore
// - five-second hold in A/D captures mask
// - mode LED flashes after three held seconds in A, B and D
// - five-second hold in B toggles manager role
// - manager enable also enables media redundancy
// - ring LED: off, green, flashing on switch-through
// - standby LED: off, green, flashing when active
// - startup fault LED: red, flashing, then off
// - runtime error lights red, opens contact
// - supply LEDs green above threshold in A-C
// - combined supply LED off, orange, green
// - mode D supply LEDs show mask membership
// - mode A port LED: off or green
// - blocking port flashes once per second
// - management-disabled port flashes three per second
// - mirror destination port flashes four per second
// - mode D port LEDs show mask membership
`ifndef FRONT_PANEL_REGS_SVH
`define FRONT_PANEL_REGS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define REG_CTRL_ADDR        8'h00
`define REG_STATUS_ADDR      8'h04
`define REG_MASK_ADDR        8'h08

`define CTRL_STANDBY_BIT     0
`define CTRL_MEDIA_RED_BIT   1
`define CTRL_MANAGER_BIT     2
`define CTRL_SW_ERROR_BIT    3
`define CTRL_RESET_VALUE     4'h0

`define STATUS_MODE_LSB      0
`define STATUS_STARTUP_BIT   2
`define STATUS_ERROR_BIT     3
`define STATUS_RESTORED_BIT  4
`define STATUS_CAPTURED_BIT  5

`define MASK_SUPPLY_LSB      0
`define MASK_PORT_LSB        2
`define MASK_RESET_VALUE     4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_HZ               10000000
`define T_FACTORY_S          12
`define T_HOLD_S             5
`define T_HOLD_FLASH_S       3
`define T_IDLE_S             60
`define T_DEBOUNCE_MS        10
`define FLASH_GENERAL_HZ     2
`define FLASH_SLOW_HZ        1
`define FLASH_DISABLED_HZ    3
`define FLASH_MIRROR_HZ      4

`define FACTORY_CYC          (`T_FACTORY_S * `CLK_HZ)
`define HOLD_CYC             (`T_HOLD_S * `CLK_HZ)
`define HOLD_FLASH_CYC       (`T_HOLD_FLASH_S * `CLK_HZ)
`define IDLE_CYC             (`T_IDLE_S * `CLK_HZ + 1)
`define DEBOUNCE_CYC         ((`T_DEBOUNCE_MS * `CLK_HZ + 999) / 1000)
`define HALF_CYC(hz)         (`CLK_HZ / (2 * (hz)))

`endif

// ==== verilog/front_panel_pkg.sv ====
// types shared by the front-panel controller
package front_panel_pkg;

  typedef enum logic [1:0] {MODE_A, MODE_B, MODE_C, MODE_D} display_mode_t;

  // bicolour led: both on reads as orange
  typedef struct packed {
    logic red;
    logic green;
  } led_t;

  typedef struct packed {
    logic link;
    logic blocking;
    logic disabled;
    logic mirror;
  } port_status_t;

endpackage

// ==== verilog/front_panel_button_led_ctrl.sv ====
// front-panel button timing, indicator encoding and apb register file
`timescale 1ns/1ps
`default_nettype none
`include "front_panel_regs.svh"

module front_panel_button_led_ctrl #(
  parameter int unsigned FACTORY_CYCLES    = `FACTORY_CYC,
  parameter int unsigned HOLD_CYCLES       = `HOLD_CYC,
  parameter int unsigned HOLD_FLASH_CYCLES = `HOLD_FLASH_CYC,
  parameter int unsigned IDLE_CYCLES       = `IDLE_CYC,
  parameter int unsigned DEBOUNCE_CYCLES   = `DEBOUNCE_CYC,
  parameter int unsigned HALF_GENERAL      = `HALF_CYC(`FLASH_GENERAL_HZ),
  parameter int unsigned HALF_SLOW         = `HALF_CYC(`FLASH_SLOW_HZ),
  parameter int unsigned HALF_DISABLED     = `HALF_CYC(`FLASH_DISABLED_HZ),
  parameter int unsigned HALF_MIRROR       = `HALF_CYC(`FLASH_MIRROR_HZ)
) (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  // button, high while pressed
  input  wire logic                           button_in,
  // device state
  input  wire logic [1:0]                     supply_good,
  input  wire front_panel_pkg::port_status_t  port_one_status,
  input  wire front_panel_pkg::port_status_t  port_two_status,
  input  wire logic                           ring_switched,
  input  wire logic                           standby_active,
  input  wire logic                           startup_done,
  input  wire logic                           firmware_bad,
  // indicators
  output front_panel_pkg::led_t               mode_indicator_led,
  output front_panel_pkg::led_t               ring_manager_led,
  output front_panel_pkg::led_t               standby_led,
  output front_panel_pkg::led_t               fault_led,
  output front_panel_pkg::led_t               supply_one_led,
  output front_panel_pkg::led_t               supply_two_led,
  output front_panel_pkg::led_t               supply_combined_led,
  output front_panel_pkg::led_t               port_one_led,
  output front_panel_pkg::led_t               port_two_led,
  // contact and events
  output logic                                signal_contact_open,
  output logic                                factory_reset_pulse
);

  // ----------------------------------------------------------------------
  // button synchroniser and debouncer
  // ----------------------------------------------------------------------
  logic        btn_meta;
  logic        btn_sync;
  logic        btn_level;
  logic        btn_level_q;
  logic [31:0] bounce_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_meta <= 1'b0;
      btn_sync <= 1'b0;
    end
    else
    begin
      btn_meta <= button_in;
      btn_sync <= btn_meta;
    end
  end

  // level must stay changed for the whole window before it is adopted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bounce_cnt <= 32'h0000_0000;
      btn_level  <= 1'b0;
    end
    else if (btn_sync == btn_level)
      bounce_cnt <= 32'h0000_0000;
    else if (bounce_cnt >= DEBOUNCE_CYCLES - 1)
    begin
      bounce_cnt <= 32'h0000_0000;
      btn_level  <= btn_sync;
    end
    else
      bounce_cnt <= bounce_cnt + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      btn_level_q <= 1'b0;
    else
      btn_level_q <= btn_level;
  end

  // ----------------------------------------------------------------------
  // press and idle timers
  // ----------------------------------------------------------------------
  logic [31:0] press_cnt;
  logic [31:0] idle_cnt;

  // saturates so a very long hold never wraps into a fresh threshold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      press_cnt <= 32'h0000_0000;
    else if (!btn_level)
      press_cnt <= 32'h0000_0000;
    else if (press_cnt < FACTORY_CYCLES)
      press_cnt <= press_cnt + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_cnt <= 32'h0000_0000;
    else if (btn_level)
      idle_cnt <= 32'h0000_0000;
    else if (idle_cnt < IDLE_CYCLES)
      idle_cnt <= idle_cnt + 32'h0000_0001;
  end

  front_panel_pkg::display_mode_t mode;
  front_panel_pkg::display_mode_t next_mode;

  wire release_edge = btn_level_q & ~btn_level;
  wire brief_press  = release_edge & (press_cnt < HOLD_FLASH_CYCLES);
  wire idle_expired = ~btn_level & (idle_cnt == IDLE_CYCLES - 1);
  // each hold event fires once, in the cycle the count reaches its mark
  wire hold_mark    = btn_level & (press_cnt == HOLD_CYCLES - 1);
  wire factory_mark = btn_level & (press_cnt == FACTORY_CYCLES - 1);
  wire mode_a       = (mode == front_panel_pkg::MODE_A);
  wire mode_b       = (mode == front_panel_pkg::MODE_B);
  wire mode_d       = (mode == front_panel_pkg::MODE_D);
  wire do_factory   = factory_mark & mode_a;
  wire do_capture   = hold_mark & (mode_a | mode_d);
  wire do_toggle    = hold_mark & mode_b;
  wire hold_flash   = btn_level & (press_cnt >= HOLD_FLASH_CYCLES)
                      & (mode_a | mode_b | mode_d);

  // ----------------------------------------------------------------------
  // display mode
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    if (brief_press)
    begin
      unique case (mode)
        front_panel_pkg::MODE_A: next_mode = front_panel_pkg::MODE_B;
        front_panel_pkg::MODE_B: next_mode = front_panel_pkg::MODE_C;
        front_panel_pkg::MODE_C: next_mode = front_panel_pkg::MODE_D;
        front_panel_pkg::MODE_D: next_mode = front_panel_pkg::MODE_A;
      endcase
    end
    else if (idle_expired)
      next_mode = front_panel_pkg::MODE_A;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= front_panel_pkg::MODE_A;
    else
      mode <= next_mode;
  end

  // ----------------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------------
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [3:0] fault_mask;
  logic [3:0] next_fault_mask;
  logic       restored_flag;
  logic       captured_flag;
  logic       sys_error;

  wire apb_write  = psel & penable & pwrite;
  wire sel_ctrl   = (paddr == `REG_CTRL_ADDR);
  wire sel_status = (paddr == `REG_STATUS_ADDR);
  wire sel_mask   = (paddr == `REG_MASK_ADDR);
  wire addr_ok    = sel_ctrl | sel_status | sel_mask;
  wire wr_ctrl    = apb_write & sel_ctrl;
  wire wr_mask    = apb_write & sel_mask;
  wire clr_rest   = apb_write & sel_status & pwdata[`STATUS_RESTORED_BIT];
  wire clr_capt   = apb_write & sel_status & pwdata[`STATUS_CAPTURED_BIT];
  wire [3:0] live_state = {port_two_status.link, port_one_status.link, supply_good};

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // button events override a software write landing in the same cycle
  always_comb
  begin
    next_ctrl = wr_ctrl ? pwdata[3:0] : ctrl;
    if (do_toggle)
    begin
      next_ctrl[`CTRL_MANAGER_BIT] = ~ctrl[`CTRL_MANAGER_BIT];
      if (!ctrl[`CTRL_MANAGER_BIT])
        next_ctrl[`CTRL_MEDIA_RED_BIT] = 1'b1;
    end
    if (do_factory)
      next_ctrl = `CTRL_RESET_VALUE;
  end

  always_comb
  begin
    next_fault_mask = wr_mask ? pwdata[3:0] : fault_mask;
    if (do_capture)
      next_fault_mask = live_state;
    if (do_factory)
      next_fault_mask = `MASK_RESET_VALUE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl       <= `CTRL_RESET_VALUE;
      fault_mask <= `MASK_RESET_VALUE;
    end
    else
    begin
      ctrl       <= next_ctrl;
      fault_mask <= next_fault_mask;
    end
  end

  // sticky event flags, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      restored_flag       <= 1'b0;
      captured_flag       <= 1'b0;
      factory_reset_pulse <= 1'b0;
    end
    else
    begin
      restored_flag       <= do_factory | (restored_flag & ~clr_rest);
      captured_flag       <= do_capture | (captured_flag & ~clr_capt);
      factory_reset_pulse <= do_factory;
    end
  end

  wire [31:0] status_word = {26'h000_0000, captured_flag, restored_flag,
                             sys_error, startup_done, mode};
  wire [31:0] read_word   = sel_ctrl   ? {28'h000_0000, ctrl} :
                            sel_status ? status_word :
                            sel_mask   ? {28'h000_0000, fault_mask} :
                                         32'h0000_0000;

  // captured in the setup cycle so the access cycle sees a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= read_word;
  end

  // ----------------------------------------------------------------------
  // flash generators
  // ----------------------------------------------------------------------
  localparam int unsigned FLASH_N = 4;
  logic [31:0] flash_cnt [FLASH_N];
  logic [FLASH_N-1:0] flash;
  wire  [31:0] flash_half [FLASH_N];

  assign flash_half[0] = HALF_GENERAL;
  assign flash_half[1] = HALF_SLOW;
  assign flash_half[2] = HALF_DISABLED;
  assign flash_half[3] = HALF_MIRROR;

  for (genvar i = 0; i < FLASH_N; i++)
  begin : g_flash
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        flash_cnt[i] <= 32'h0000_0000;
        flash[i]     <= 1'b0;
      end
      else if (flash_cnt[i] >= flash_half[i] - 1)
      begin
        flash_cnt[i] <= 32'h0000_0000;
        flash[i]     <= ~flash[i];
      end
      else
        flash_cnt[i] <= flash_cnt[i] + 32'h0000_0001;
    end
  end

  wire blink   = flash[0];
  wire blink_1 = flash[1];
  wire blink_3 = flash[2];
  wire blink_4 = flash[3];

  // ----------------------------------------------------------------------
  // fault and contact
  // ----------------------------------------------------------------------
  // unmasked supplies and ports never count as an error
  assign sys_error = ctrl[`CTRL_SW_ERROR_BIT]
                     | |(fault_mask[1:0] & ~supply_good)
                     | |(fault_mask[3:2] & ~live_state[3:2]);

  // ----------------------------------------------------------------------
  // indicator encoding
  // ----------------------------------------------------------------------
  localparam front_panel_pkg::led_t LED_OFF    = 2'h0;
  localparam front_panel_pkg::led_t LED_GREEN  = 2'h1;
  localparam front_panel_pkg::led_t LED_RED    = 2'h2;
  localparam front_panel_pkg::led_t LED_ORANGE = 2'h3;

  function automatic front_panel_pkg::led_t port_led(
    input front_panel_pkg::port_status_t st,
    input front_panel_pkg::display_mode_t md,
    input logic masked,
    input logic b1,
    input logic b3,
    input logic b4
  );
    port_led = LED_OFF;
    if (md == front_panel_pkg::MODE_A && st.link)
    begin
      if (st.mirror)
        port_led = b4 ? LED_GREEN : LED_OFF;
      else if (st.disabled)
        port_led = b3 ? LED_GREEN : LED_OFF;
      else if (st.blocking)
        port_led = b1 ? LED_GREEN : LED_OFF;
      else
        port_led = LED_GREEN;
    end
    else if (md == front_panel_pkg::MODE_D)
      port_led = masked ? LED_GREEN : LED_OFF;
  endfunction

  front_panel_pkg::led_t next_mode_led;
  front_panel_pkg::led_t next_ring_led;
  front_panel_pkg::led_t next_standby_led;
  front_panel_pkg::led_t next_fault_led;
  front_panel_pkg::led_t next_sup1_led;
  front_panel_pkg::led_t next_sup2_led;
  front_panel_pkg::led_t next_comb_led;
  logic [1:0]            sup_shown;

  always_comb
  begin
    unique case (mode)
      front_panel_pkg::MODE_A: next_mode_led = LED_OFF;
      front_panel_pkg::MODE_B: next_mode_led = LED_GREEN;
      front_panel_pkg::MODE_C: next_mode_led = LED_ORANGE;
      front_panel_pkg::MODE_D: next_mode_led = blink ? LED_ORANGE : LED_GREEN;
    endcase
    // mode A has no colour of its own, so its hold flash uses green
    if (hold_flash)
      next_mode_led = !blink ? LED_OFF : (mode_a ? LED_GREEN : next_mode_led);
  end

  always_comb
  begin
    if (!ctrl[`CTRL_MANAGER_BIT])
      next_ring_led = LED_OFF;
    else if (ring_switched)
      next_ring_led = blink ? LED_GREEN : LED_OFF;
    else
      next_ring_led = LED_GREEN;
  end

  always_comb
  begin
    if (!ctrl[`CTRL_STANDBY_BIT])
      next_standby_led = LED_OFF;
    else if (standby_active)
      next_standby_led = blink ? LED_GREEN : LED_OFF;
    else
      next_standby_led = LED_GREEN;
  end

  always_comb
  begin
    if (!startup_done)
      next_fault_led = (firmware_bad & ~blink) ? LED_OFF : LED_RED;
    else
      next_fault_led = sys_error ? LED_RED : LED_OFF;
  end

  // mode D shows the mask, the other modes the live supplies
  assign sup_shown = mode_d ? fault_mask[1:0] : supply_good;

  always_comb
  begin
    next_sup1_led = sup_shown[0] ? LED_GREEN : LED_OFF;
    next_sup2_led = sup_shown[1] ? LED_GREEN : LED_OFF;
    unique case (sup_shown)
      2'h0:    next_comb_led = LED_OFF;
      2'h3:    next_comb_led = LED_GREEN;
      default: next_comb_led = LED_ORANGE;
    endcase
  end

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_indicator_led  <= LED_OFF;
      ring_manager_led    <= LED_OFF;
      standby_led         <= LED_OFF;
      fault_led           <= LED_OFF;
      supply_one_led      <= LED_OFF;
      supply_two_led      <= LED_OFF;
      supply_combined_led <= LED_OFF;
      port_one_led        <= LED_OFF;
      port_two_led        <= LED_OFF;
      signal_contact_open <= 1'b1;
    end
    else
    begin
      mode_indicator_led  <= next_mode_led;
      ring_manager_led    <= next_ring_led;
      standby_led         <= next_standby_led;
      fault_led           <= next_fault_led;
      supply_one_led      <= next_sup1_led;
      supply_two_led      <= next_sup2_led;
      supply_combined_led <= next_comb_led;
      port_one_led        <= port_led(port_one_status, mode, fault_mask[2],
                                      blink_1, blink_3, blink_4);
      port_two_led        <= port_led(port_two_status, mode, fault_mask[3],
                                      blink_1, blink_3, blink_4);
      // contact is held open until startup ends, fail-safe for the relay
      signal_contact_open <= ~startup_done | sys_error;
    end
  end

endmodule
`default_nettype wire

// ==== verification/button_model.sv ====
// push-button model with contact bounce on press and release
`timescale 1ns/1ps
`default_nettype none
module button_model (
  // clock
  input  wire logic pclk,
  // button, high while pressed
  output logic      button_in
);
  initial button_in = 1'b0;
  // --------------------------------
  // one press held n cycles
  // --------------------------------
  // one-cycle chatter on both edges must never count as extra presses
  task automatic press(input int n);
    button_in <= 1'b1;
    @(posedge pclk);
    button_in <= 1'b0;
    @(posedge pclk);
    button_in <= 1'b1;
    repeat (n) @(posedge pclk);
    button_in <= 1'b0;
    @(posedge pclk);
    button_in <= 1'b1;
    @(posedge pclk);
    button_in <= 1'b0;
    // settle time so the release is seen before the next request
    repeat (12) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== verification/front_panel_chk.sv ====
// port assertions for the front-panel controller
`timescale 1ns/1ps
`default_nettype none
module front_panel_chk #(
  parameter int unsigned IDLE_CYCLES = 200
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // watched inputs
  input  wire logic                  button_in,
  input  wire logic                  startup_done,
  input  wire logic                  firmware_bad,
  // indicators
  input  wire front_panel_pkg::led_t mode_indicator_led,
  input  wire front_panel_pkg::led_t ring_manager_led,
  input  wire front_panel_pkg::led_t standby_led,
  input  wire front_panel_pkg::led_t fault_led,
  input  wire front_panel_pkg::led_t port_one_led,
  input  wire front_panel_pkg::led_t port_two_led,
  // contact and events
  input  wire logic                  signal_contact_open,
  input  wire logic                  factory_reset_pulse
);
  int unsigned idle_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // saturating, so a long idle never wraps back to a small count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      idle_cnt <= 0;
    else if (button_in)
      idle_cnt <= 0;
    else if (idle_cnt < IDLE_CYCLES + 20)
      idle_cnt <= idle_cnt + 1;
  sequence s_bad;
    (!startup_done && firmware_bad)[*8];
  endsequence
  sequence s_up;
    $past(presetn) && $past(startup_done);
  endsequence
  AST_CONTACT: assert property (s_up |-> signal_contact_open == fault_led.red)
    else $error("contact and fault led disagree");
  AST_START_RED: assert property ($past(presetn) && !$past(startup_done)
    && !$past(firmware_bad) |-> fault_led == 2'b10 && signal_contact_open)
    else $error("fault led not red in startup");
  AST_FW_FLASH: assert property (s_bad |-> !fault_led.green
    && fault_led.red != $past(fault_led.red, 4))
    else $error("fault led not flashing on bad image");
  AST_FACT_PULSE: assert property (factory_reset_pulse |=> !factory_reset_pulse)
    else $error("restore pulse longer than one cycle");
  AST_FACT_HELD: assert property (factory_reset_pulse |-> $past(button_in, 30))
    else $error("restore without a held button");
  AST_IDLE: assert property (idle_cnt >= IDLE_CYCLES + 15 |-> mode_indicator_led == 2'b00)
    else $error("no return to mode a after idle");
  AST_MODE_LED: assert property (mode_indicator_led != 2'b10)
    else $error("mode led shows red");
  AST_RING_SB: assert property (!ring_manager_led.red && !standby_led.red)
    else $error("ring or standby led shows red");
  AST_PORT_GREEN: assert property (!port_one_led.red && !port_two_led.red)
    else $error("port led shows red");
endmodule
bind front_panel_button_led_ctrl front_panel_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .button_in(button_in), .startup_done(startup_done),
  .firmware_bad(firmware_bad), .mode_indicator_led(mode_indicator_led),
  .ring_manager_led(ring_manager_led), .standby_led(standby_led), .fault_led(fault_led),
  .port_one_led(port_one_led), .port_two_led(port_two_led),
  .signal_contact_open(signal_contact_open), .factory_reset_pulse(factory_reset_pulse));
`default_nettype wire

// ==== verification/front_panel_button_led_ctrl_tb.sv ====
// testbench for the front-panel controller
`timescale 1ns/1ps
`default_nettype none
`include "front_panel_regs.svh"
module front_panel_button_led_ctrl_tb;
  logic                          pclk, presetn, psel, penable, pwrite, ring_sw, sb_act;
  logic                          up, fw_bad, pready, pslverr, button_in, err, contact, fpulse;
  logic [7:0]                    paddr;
  logic [31:0]                   pwdata, prdata, q;
  logic [1:0]                    supply_good;
  front_panel_pkg::port_status_t p1, p2;
  front_panel_pkg::led_t         mode_led, ring_led, sb_led, f_led, s1_led, s2_led;
  front_panel_pkg::led_t         sc_led, p1_led, p2_led;
  int                            n_mismatch = 0, cmp_count = 0, n_pulse = 0, i;
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (fpulse === 1'b1) n_pulse <= n_pulse + 1;
  button_model bm (.pclk(pclk), .button_in(button_in));
  front_panel_button_led_ctrl #(.FACTORY_CYCLES(120), .HOLD_CYCLES(50),
    .HOLD_FLASH_CYCLES(30), .IDLE_CYCLES(200), .DEBOUNCE_CYCLES(4), .HALF_GENERAL(4),
    .HALF_SLOW(5), .HALF_DISABLED(3), .HALF_MIRROR(2)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .button_in(button_in), .supply_good(supply_good), .port_one_status(p1),
    .port_two_status(p2), .ring_switched(ring_sw), .standby_active(sb_act),
    .startup_done(up), .firmware_bad(fw_bad), .mode_indicator_led(mode_led),
    .ring_manager_led(ring_led), .standby_led(sb_led), .fault_led(f_led),
    .supply_one_led(s1_led), .supply_two_led(s2_led), .supply_combined_led(sc_led),
    .port_one_led(p1_led), .port_two_led(p2_led), .signal_contact_open(contact),
    .factory_reset_pulse(fpulse));
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo;
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // holds the request until pready is sampled high, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 20) tmo();
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [1:0] pick(input int s);
    case (s)
      0: pick = p1_led;
      1: pick = ring_led;
      2: pick = sb_led;
      default: pick = mode_led;
    endcase
  endfunction
  // first loop finds an edge, second measures the half period
  task automatic half(input int s, input int e);
    logic [1:0] v;
    int         n;
    for (int k = 0; k < 2; k++)
    begin
      v = pick(s);
      n = 0;
      while (pick(s) === v)
      begin
        @(posedge pclk);
        n++;
        if (n > 40) tmo();
      end
    end
    chk(n, e);
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, ring_sw, sb_act, up} <= 8'h00;
    {paddr, pwdata, fw_bad, supply_good} <= {8'h00, 32'h0000_0000, 1'b1, 2'h3};
    {p1, p2} <= 8'h80;
    wt(5);
    presetn <= 1'b1;
    wt(14);
    chk({f_led.green, contact}, 2'b01);
    fw_bad <= 1'b0;
    wt(3);
    chk(f_led, 2'b10);
    up <= 1'b1;
    wt(3);
    chk({f_led, contact}, 3'b000);
    $display("test startup done");
    for (i = 1; i < 4; i++)
    begin
      bm.press(10);
      apb(1'b0, `REG_STATUS_ADDR, 32'h0);
      chk(q[1:0], i);
      if (i < 3) chk(mode_led, 2 * i - 1);
    end
    half(3, 4);
    supply_good <= 2'h1;
    bm.press(60);
    apb(1'b0, `REG_MASK_ADDR, 32'h0);
    chk(q, 32'h5);
    apb(1'b0, `REG_STATUS_ADDR, 32'h0);
    chk(q[1:0], 2'h3);
    chk({s1_led, s2_led, p1_led, p2_led}, 8'h44);
    supply_good <= 2'h2;
    wt(3);
    chk(contact, 1'b1);
    supply_good <= 2'h1;
    p1 <= 4'h0;
    wt(3);
    chk(contact, 1'b1);
    p1 <= 4'h8;
    wt(3);
    chk(contact, 1'b0);
    bm.press(10);
    apb(1'b0, `REG_STATUS_ADDR, 32'h0);
    chk(q[1:0], 2'h0);
    $display("test mask done");
    p2 <= 4'h8;
    for (i = 0; i < 4; i++)
    begin
      supply_good <= i[1:0];
      wt(3);
      chk(sc_led, i == 0 ? 0 : (i == 3 ? 1 : 3));
      chk(s1_led, i & 1);
    end
    chk({p1_led, p2_led}, 4'h5);
    p1 <= 4'h9;
    half(0, 2);
    p1 <= 4'hA;
    half(0, 3);
    p1 <= 4'hC;
    half(0, 5);
    p1 <= 4'h0;
    wt(3);
    chk(p1_led, 2'b00);
    p1 <= 4'h8;
    bm.press(10);
    bm.press(60);
    apb(1'b0, `REG_CTRL_ADDR, 32'h0);
    chk(q, 32'h6);
    chk(ring_led, 2'b01);
    ring_sw <= 1'b1;
    half(1, 4);
    ring_sw <= 1'b0;
    bm.press(60);
    apb(1'b0, `REG_CTRL_ADDR, 32'h0);
    chk(q, 32'h2);
    bm.press(40);
    apb(1'b0, `REG_CTRL_ADDR, 32'h0);
    chk(q, 32'h2);
    apb(1'b0, `REG_STATUS_ADDR, 32'h0);
    chk(q[1:0], 2'h1);
    wt(230);
    apb(1'b0, `REG_STATUS_ADDR, 32'h0);
    chk(q[1:0], 2'h0);
    $display("test manager done");
    bm.press(100);
    apb(1'b0, `REG_CTRL_ADDR, 32'h0);
    chk({n_pulse[0], q}, 33'h2);
    bm.press(140);
    chk(n_pulse, 1);
    apb(1'b0, `REG_CTRL_ADDR, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `REG_MASK_ADDR, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `REG_STATUS_ADDR, 32'h0);
    chk(q, 32'h34);
    apb(1'b1, `REG_STATUS_ADDR, 32'h30);
    apb(1'b0, `REG_STATUS_ADDR, 32'h0);
    chk(q, 32'h4);
    apb(1'b1, `REG_CTRL_ADDR, 32'h1);
    wt(3);
    chk(sb_led, 2'b01);
    sb_act <= 1'b1;
    half(2, 4);
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, q}, 33'h100000000);
    $display("test restore done");
    report_and_stop();
  end
endmodule
`default_nettype wire
